// ### inc/iwdg_pkg.sv
// Shared constants and types of the independent watchdog.
package iwdg_pkg;

  // Widths
  localparam int unsigned PRE_STAGES = 8;
  localparam int unsigned CNT_W      = 12;
  localparam int unsigned PSC_W      = 3;
  localparam int unsigned CMD_W      = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CMD  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PSC  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RLD  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'hC;

  // Command keys
  localparam logic [CMD_W-1:0] KEY_UNLOCK = 16'h5555;
  localparam logic [CMD_W-1:0] KEY_START  = 16'hCCCC;
  localparam logic [CMD_W-1:0] KEY_RELOAD = 16'hAAAA;

  // Field positions
  localparam int unsigned PSC_LSB      = 0;
  localparam int unsigned RLD_LSB      = 0;
  localparam int unsigned CMD_LSB      = 0;
  localparam int unsigned STAT_PSC_BIT = 0;
  localparam int unsigned STAT_RLD_BIT = 1;
  localparam int unsigned N_UPD        = 2;

  // Reset values
  localparam logic [PSC_W-1:0] RST_PSC = 3'h0;
  localparam logic [CNT_W-1:0] RST_RLD = 12'hFFF;
  localparam logic [CNT_W-1:0] RST_CNT = 12'hFFF;

  // Prescaler decode: code 0 is divide by 4, codes 6 and 7 divide by 256
  localparam logic [PSC_W-1:0] PSC_MAX_CODE = 3'h6;
  localparam logic [3:0]       PRE_MIN_LOG2 = 4'h2;
  localparam logic [3:0]       PRE_MAX_LOG2 = 4'h8;

  // Oscillator edges a register update needs to reach the counter side
  localparam logic [1:0] UPD_OSC_EDGES = 2'h2;

  typedef enum {
    IWDG_IDLE,
    IWDG_RUN,
    IWDG_FIRED
  } iwdg_state_e;

endpackage : iwdg_pkg

// ### inc/iwdg_core_if.sv
// Signals between the watchdog control logic, prescaler and counter.
`timescale 1ns/1ps
interface iwdg_core_if;
  logic                      adv;
  logic                      clr_pre;
  logic [iwdg_pkg::PSC_W-1:0] psc_code;
  logic                      dec_tick;
  logic                      load;
  logic [iwdg_pkg::CNT_W-1:0] load_val;
  logic [iwdg_pkg::CNT_W-1:0] count;
  logic                      zero;

  modport ctl (output adv, clr_pre, psc_code, load, load_val, input count, zero);
  modport pre (input adv, clr_pre, psc_code, output dec_tick);
  modport cnt (input dec_tick, load, load_val, output count, zero);
endinterface : iwdg_core_if

// ### src/iwdg_prescaler.sv
// Eight-stage prescaler producing the counter decrement tick.
`timescale 1ns/1ps
module iwdg_prescaler (
  // Clock, reset, enable
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Core link
  iwdg_core_if.pre  core
);

  logic [iwdg_pkg::PRE_STAGES-1:0] stage_q;
  logic [iwdg_pkg::PRE_STAGES:0]   carry;
  logic [3:0]                      tap;

  assign carry[0] = core.adv;

  // Each stage passes the carry on when its bit is set
  genvar k;
  generate
    for (k = 0; k < iwdg_pkg::PRE_STAGES; k++) begin : g_stage
      assign carry[k+1] = carry[k] & stage_q[k];
    end
  endgenerate

  assign tap = (core.psc_code >= iwdg_pkg::PSC_MAX_CODE) ? iwdg_pkg::PRE_MAX_LOG2
                                                      : iwdg_pkg::PRE_MIN_LOG2 + {1'b0, core.psc_code};
  assign core.dec_tick = carry[tap];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_q <= '0;
    end else if (ce_i) begin
      if (core.clr_pre) begin
        stage_q <= '0;
      end else if (core.adv) begin
        stage_q <= stage_q + 8'h01;
      end
    end
  end

endmodule : iwdg_prescaler

// ### src/iwdg_counter.sv
// Twelve-bit down-counter with reload.
`timescale 1ns/1ps
module iwdg_counter (
  // Clock, reset, enable
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Core link
  iwdg_core_if.cnt  core
);

  logic [iwdg_pkg::CNT_W-1:0] count_q;

  assign core.count = count_q;
  assign core.zero  = (count_q == '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= iwdg_pkg::RST_CNT;
    end else if (ce_i) begin
      if (core.load) begin
        count_q <= core.load_val;
      end else if (core.dec_tick && !core.zero) begin
        count_q <= count_q - 12'h001;
      end
    end
  end

endmodule : iwdg_counter

// ### src/iwdg_top.sv
// Independent watchdog: register port, key handling, update tracking and control.
// What this block does
// - Eight-stage prescaler drives a twelve-bit down-counter.
// - Command 0xCCCC enables the watchdog and starts counting down.
// - While enabled, reaching zero asserts the system reset.
// - Command 0xAAAA loads the counter from the reload register, any time.
// - Hardware option bit starts counting after power-on without software.
// - Prescaler and reload registers writable only after unlock key 0x5555.
// - Any other command value re-locks prescaler and reload registers.
// - Status bit stays set while its register update is in progress.
// - In debug halt, counting stops only if the freeze control is set.
// - Counter advances only on the independent low-speed oscillator.
// - Prescale code 0 divides by 4, doubling, 6 and 7 give 256.
// - Prescaler read-back is invalid while its update is pending.
// - Command register is write-only, 16-bit command in the low half.
// - Registers accept half-word and word accesses.
// - Reload register holds a protected 12-bit value, resetting to all ones.
// - Status bit 1 is reload pending, bit 0 prescale pending.
`timescale 1ns/1ps
module iwdg_top (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic        reg_sel_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_half_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_ack_o,
  output logic             reg_err_o,
  // Oscillator, option and debug
  input  wire logic        low_speed_internal_osc_i,
  input  wire logic        hw_watchdog_opt_i,
  input  wire logic        dbg_halt_i,
  input  wire logic        debug_freeze_control_i,
  // System reset request
  output logic             wdg_reset_o
);

  localparam int unsigned NU = iwdg_pkg::N_UPD;

  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  iwdg_core_if core ();

  // Oscillator edge detection
  logic osc_q;
  logic osc_tick;

  assign osc_tick = low_speed_internal_osc_i & ~osc_q;

  // Register decode
  logic                      acc;
  logic                      wr;
  logic                      wr_low;
  logic                      hit_cmd;
  logic                      hit_psc;
  logic                      hit_rld;
  logic                      hit_stat;
  logic                      mapped;
  logic [iwdg_pkg::CMD_W-1:0] cmd_val;
  logic                      cmd_wr;
  logic                      cmd_unlock;
  logic                      cmd_start;
  logic                      cmd_reload;

  assign acc      = reg_sel_i & ce_i;
  assign wr       = acc & reg_we_i;
  // Fields live in the low half; a half-word write to the upper half is dropped
  assign wr_low   = wr & ~(reg_half_i & reg_addr_i[1]);
  assign hit_cmd  = ({reg_addr_i[3:2], 2'b00} == iwdg_pkg::OFS_CMD);
  assign hit_psc  = ({reg_addr_i[3:2], 2'b00} == iwdg_pkg::OFS_PSC);
  assign hit_rld  = ({reg_addr_i[3:2], 2'b00} == iwdg_pkg::OFS_RLD);
  assign hit_stat = ({reg_addr_i[3:2], 2'b00} == iwdg_pkg::OFS_STAT);
  assign mapped   = hit_cmd | hit_psc | hit_rld | hit_stat;

  assign cmd_val    = reg_wdata_i[iwdg_pkg::CMD_LSB +: iwdg_pkg::CMD_W];
  assign cmd_wr     = wr_low & hit_cmd;
  assign cmd_unlock = cmd_wr & (cmd_val == iwdg_pkg::KEY_UNLOCK);
  assign cmd_start  = cmd_wr & (cmd_val == iwdg_pkg::KEY_START);
  assign cmd_reload = cmd_wr & (cmd_val == iwdg_pkg::KEY_RELOAD);

  // Write protection
  logic unlock_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= 1'b0;
      osc_q    <= 1'b0;
    end else if (ce_i) begin
      osc_q <= low_speed_internal_osc_i;
      if (cmd_wr) begin
        unlock_q <= cmd_unlock;
      end
    end
  end

  // Protected register writes; locked writes leave everything untouched
  logic [NU-1:0] upd_wr;

  assign upd_wr[iwdg_pkg::STAT_PSC_BIT] = wr_low & hit_psc & unlock_q;
  assign upd_wr[iwdg_pkg::STAT_RLD_BIT] = wr_low & hit_rld & unlock_q;

  // Values written by software, waiting to reach the counter side
  logic [iwdg_pkg::PSC_W-1:0] psc_new_q;
  logic [iwdg_pkg::CNT_W-1:0] rld_new_q;
  // Values in force on the counter side
  logic [iwdg_pkg::PSC_W-1:0] psc_act_q;
  logic [iwdg_pkg::CNT_W-1:0] rld_act_q;

  // Update tracking: a transfer needs a few oscillator edges to land
  logic [NU-1:0] pend_q;
  logic [NU-1:0] commit;
  logic [1:0]    pend_cnt_q [NU];

  genvar u;
  generate
    for (u = 0; u < NU; u++) begin : g_upd
      logic last_edge;

      assign last_edge = pend_q[u] & osc_tick & (pend_cnt_q[u] == iwdg_pkg::UPD_OSC_EDGES - 2'h1);
      // A new write in the finishing cycle restarts the transfer
      assign commit[u] = last_edge & ~upd_wr[u];

      always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          pend_q[u]     <= 1'b0;
          pend_cnt_q[u] <= 2'h0;
        end else if (ce_i) begin
          if (upd_wr[u]) begin
            pend_q[u]     <= 1'b1;
            pend_cnt_q[u] <= 2'h0;
          end else if (last_edge) begin
            pend_q[u] <= 1'b0;
          end else if (pend_q[u] && osc_tick) begin
            pend_cnt_q[u] <= pend_cnt_q[u] + 2'h1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      psc_new_q <= iwdg_pkg::RST_PSC;
      rld_new_q <= iwdg_pkg::RST_RLD;
      psc_act_q <= iwdg_pkg::RST_PSC;
      rld_act_q <= iwdg_pkg::RST_RLD;
    end else if (ce_i) begin
      if (upd_wr[iwdg_pkg::STAT_PSC_BIT]) begin
        psc_new_q <= reg_wdata_i[iwdg_pkg::PSC_LSB +: iwdg_pkg::PSC_W];
      end
      if (upd_wr[iwdg_pkg::STAT_RLD_BIT]) begin
        rld_new_q <= reg_wdata_i[iwdg_pkg::RLD_LSB +: iwdg_pkg::CNT_W];
      end
      if (commit[iwdg_pkg::STAT_PSC_BIT]) begin
        psc_act_q <= psc_new_q;
      end
      if (commit[iwdg_pkg::STAT_RLD_BIT]) begin
        rld_act_q <= rld_new_q;
      end
    end
  end

  // Power-on option: caught once, on the first enabled cycle after release
  logic opt_done_q;
  logic opt_start;

  assign opt_start = ~opt_done_q & hw_watchdog_opt_i;

  // Control state
  iwdg_pkg::iwdg_state_e state_q;
  iwdg_pkg::iwdg_state_e state_d;
  logic                  run;
  logic                  frozen;

  assign run    = (state_q == iwdg_pkg::IWDG_RUN);
  assign frozen = dbg_halt_i & debug_freeze_control_i;

  always_comb begin
    state_d = state_q;
    case (state_q)
      iwdg_pkg::IWDG_IDLE: begin
        if (cmd_start || opt_start) begin
          state_d = iwdg_pkg::IWDG_RUN;
        end
      end
      iwdg_pkg::IWDG_RUN: begin
        // A reload seen in the same cycle as zero still rescues the system
        if (core.zero && !cmd_reload) begin
          state_d = iwdg_pkg::IWDG_FIRED;
        end
      end
      iwdg_pkg::IWDG_FIRED: begin
        state_d = iwdg_pkg::IWDG_FIRED;
      end
      default: begin
        state_d = iwdg_pkg::IWDG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= iwdg_pkg::IWDG_IDLE;
      opt_done_q <= 1'b0;
    end else if (ce_i) begin
      state_q    <= state_d;
      opt_done_q <= 1'b1;
    end
  end

  // Core drive; reload uses the value already in force on the counter side
  assign core.adv      = osc_tick & run & ~frozen;
  assign core.clr_pre  = cmd_reload | cmd_start;
  assign core.psc_code = psc_act_q;
  assign core.load     = cmd_reload;
  assign core.load_val = rld_act_q;

  iwdg_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .core    (core.pre)
  );

  iwdg_counter u_cnt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .core    (core.cnt)
  );

  // Read mux; the command register reads as zero
  logic [31:0] rd_word;

  assign rd_word = hit_psc  ? {29'h0, psc_act_q} :
                   hit_rld  ? {20'h0, rld_act_q} :
                   hit_stat ? {30'h0, pend_q}    :
                   32'h0;

  // Bus answer
  logic [31:0] rdata_q;
  logic        ack_q;
  logic        err_q;
  logic        fire_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      fire_q  <= 1'b0;
    end else if (ce_i) begin
      ack_q  <= acc;
      err_q  <= acc & ~mapped;
      fire_q <= (state_d == iwdg_pkg::IWDG_FIRED);
      if (acc && !reg_we_i) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_ack_o   = ack_q;
  assign reg_err_o   = err_q;
  assign wdg_reset_o = fire_q;

endmodule : iwdg_top

// ### tb/iwdg_asserts.sv
// Port-level checks of the independent watchdog register port and reset output.
`timescale 1ns/1ps
module iwdg_asserts (
  // Clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  // Register port
  input wire logic        reg_sel_i,
  input wire logic        reg_we_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_ack_o,
  input wire logic        reg_err_o,
  // Reset request
  input wire logic        wdg_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wire rd_w = reg_sel_i && ce_i && !reg_we_i;

  acc_ack_a: assert property (reg_sel_i && ce_i ##1 ce_i |-> reg_ack_o)
    else $error("access not acknowledged");
  idle_ack_a: assert property (!(reg_sel_i && ce_i) |=> !reg_ack_o)
    else $error("ack without access");
  no_err_a: assert property (reg_ack_o |-> !reg_err_o)
    else $error("error on mapped access");
  cmd_rd_a: assert property (rd_w && reg_addr_i[3:2] == 2'h0 |=> reg_rdata_o == 32'h0)
    else $error("command read not zero");
  psc_rd_a: assert property (rd_w && reg_addr_i[3:2] == 2'h1 |=> reg_rdata_o[31:3] == 29'h0)
    else $error("prescale read upper bits set");
  rld_rd_a: assert property (rd_w && reg_addr_i[3:2] == 2'h2 |=> reg_rdata_o[31:12] == 20'h0)
    else $error("reload read upper bits set");
  stat_rd_a: assert property (rd_w && reg_addr_i[3:2] == 2'h3 |=> reg_rdata_o[31:2] == 30'h0)
    else $error("status read upper bits set");
  rdata_hold_a: assert property (!rd_w |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  fire_hold_a: assert property (wdg_reset_o |=> wdg_reset_o)
    else $error("reset request dropped");
endmodule : iwdg_asserts

bind iwdg_top iwdg_asserts u_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .reg_sel_i(reg_sel_i),
  .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
  .reg_err_o(reg_err_o), .wdg_reset_o(wdg_reset_o));

// ### tb/iwdg_top_tb.sv
// Directed register and countdown tests of the independent watchdog.
`timescale 1ns/1ps
module iwdg_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        sel = 1'b0, we = 1'b0, half = 1'b0, osc = 1'b0, halt = 1'b0, frz = 1'b0, hw_opt = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wd = 32'h0, q, rdata;
  logic        ack, err, fire;
  int          err_total = 0, n_compared = 0;

  iwdg_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .reg_sel_i(sel), .reg_we_i(we),
    .reg_half_i(half), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .reg_err_o(err), .low_speed_internal_osc_i(osc), .hw_watchdog_opt_i(hw_opt), .dbg_halt_i(halt),
    .debug_freeze_control_i(frz), .wdg_reset_o(fire));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle strobe, then bounded wait for the ack
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic h);
    int i;
    sel <= 1'b1;
    we <= w;
    addr <= a;
    wd <= d;
    half <= h;
    @(posedge clk_i);
    sel <= 1'b0;
    #1;
    for (i = 0; i < 4 && ack !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk({30'h0, ack, err}, 32'h2);
    q = rdata;
    @(posedge clk_i);
  endtask : acc

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0);
    chk(q, exp);
  endtask : rd

  // Each tick is one rising edge of the slow oscillator
  task automatic tk(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (2) @(posedge clk_i);
      osc <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask : tk

  task automatic see(input logic exp);
    repeat (6) @(posedge clk_i);
    #1;
    chk({31'h0, fire}, {31'h0, exp});
    @(posedge clk_i);
  endtask : see

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #20000;
    err_total++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(iwdg_pkg::OFS_CMD, 32'h0);
    rd(iwdg_pkg::OFS_PSC, 32'h0);
    rd(iwdg_pkg::OFS_RLD, 32'hFFF);
    rd(iwdg_pkg::OFS_STAT, 32'h0);
    acc(1'b1, iwdg_pkg::OFS_PSC, 32'h3, 1'b0);
    tk(3);
    rd(iwdg_pkg::OFS_PSC, 32'h0);
    rd(iwdg_pkg::OFS_STAT, 32'h0);
    acc(1'b1, iwdg_pkg::OFS_CMD, {16'h0, iwdg_pkg::KEY_UNLOCK}, 1'b0);
    acc(1'b1, iwdg_pkg::OFS_PSC, 32'h1, 1'b0);
    rd(iwdg_pkg::OFS_STAT, 32'h1);
    rd(iwdg_pkg::OFS_PSC, 32'h0);
    tk(2);
    rd(iwdg_pkg::OFS_STAT, 32'h0);
    rd(iwdg_pkg::OFS_PSC, 32'h1);
    acc(1'b1, iwdg_pkg::OFS_RLD, 32'h5, 1'b1);
    rd(iwdg_pkg::OFS_STAT, 32'h2);
    tk(2);
    rd(iwdg_pkg::OFS_STAT, 32'h0);
    rd(iwdg_pkg::OFS_RLD, 32'h5);
    acc(1'b1, iwdg_pkg::OFS_CMD, 32'h1234, 1'b0);
    acc(1'b1, iwdg_pkg::OFS_RLD, 32'h7, 1'b0);
    tk(2);
    rd(iwdg_pkg::OFS_RLD, 32'h5);
    rd(iwdg_pkg::OFS_STAT, 32'h0);
    // Count 5 at divide-by-8 reaches zero after 40 ticks
    acc(1'b1, iwdg_pkg::OFS_CMD, {16'h0, iwdg_pkg::KEY_START}, 1'b0);
    acc(1'b1, iwdg_pkg::OFS_CMD, {16'h0, iwdg_pkg::KEY_RELOAD}, 1'b0);
    halt <= 1'b1;
    tk(20);
    frz <= 1'b1;
    tk(40);
    halt <= 1'b0;
    frz <= 1'b0;
    tk(19);
    see(1'b0);
    tk(1);
    see(1'b1);
    rd(iwdg_pkg::OFS_STAT, 32'h0);
    // Second reset with the hardware start option set
    hw_opt <= 1'b1;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    see(1'b0);
    acc(1'b1, iwdg_pkg::OFS_CMD, {16'h0, iwdg_pkg::KEY_UNLOCK}, 1'b0);
    acc(1'b1, iwdg_pkg::OFS_RLD, 32'h1, 1'b0);
    tk(2);
    acc(1'b1, iwdg_pkg::OFS_CMD, {16'h0, iwdg_pkg::KEY_RELOAD}, 1'b0);
    tk(3);
    see(1'b0);
    tk(1);
    see(1'b1);
    finish_test();
  end
endmodule : iwdg_top_tb
